// *** logic/asc_pkg.sv ***
// asc_pkg: register map, field positions, reset values and carrier types
// for the synthesizer control register bank. assumes a 50 MHz system clock.
package asc_pkg;
    localparam int unsigned ASC_ADDR_W   = 8;
    localparam int unsigned ASC_NIB_W    = 4;
    localparam int unsigned ASC_NUM_CH   = 8;
    localparam int unsigned ASC_CH_W     = 3;
    localparam int unsigned ASC_PTR_LOCS = 15;
    localparam int unsigned ASC_PTR_W    = 4;
    localparam int unsigned ASC_SAMPLE_W = 13;
    localparam int unsigned ASC_PH_W     = 14;
    localparam int unsigned ASC_BT_W     = 4;

    // byte addresses are four times the printed index
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_ENV_LO  = 8'h06;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_ENV_HI  = 8'h07;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_CHARC   = 8'h0A;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_AUD     = 8'h0B;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_TIMER   = 8'h0C;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_DECMD   = 8'h0D;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_ENABLES = 8'h0E;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_VOL     = 8'h0F;
    localparam logic [ASC_ADDR_W-1:0] ASC_IDX_CHSEL   = 8'h12;

    localparam logic [3:0] ASC_RST_CHARC   = 4'h0;
    localparam logic [3:0] ASC_RST_VOL     = 4'h2;
    localparam logic [3:0] ASC_RST_ENABLES = 4'h0;
    localparam logic [3:0] ASC_RST_CHSEL   = 4'h0;
    localparam logic [3:0] ASC_RST_DECMD   = 4'hE;
    localparam logic [3:0] ASC_RST_TIMER   = 4'h0;
    localparam logic [7:0] ASC_RST_ENV     = 8'h00;

    localparam int unsigned ASC_EN_IRQ   = 0;
    localparam int unsigned ASC_EN_AUDIO = 1;
    localparam int unsigned ASC_EN_NFILT = 2;
    localparam int unsigned ASC_EN_MIXER = 3;
    localparam int unsigned ASC_DM_TAIL  = 1;
    localparam int unsigned ASC_DM_HDEC  = 2;
    localparam int unsigned ASC_DM_TDEC  = 3;

    localparam logic [1:0] ASC_CNT_8 = 2'b00;
    localparam logic [1:0] ASC_CNT_6 = 2'b01;
    localparam logic [1:0] ASC_CNT_4 = 2'b10;
    localparam logic [1:0] ASC_CNT_2 = 2'b11;

    localparam int unsigned ASC_CLK_HZ = 50_000_000;
    // base timer tick: shortest interval 0.064 ms = 64000 ns
    localparam int unsigned ASC_BT_BASE_NS = 64_000;
    localparam int unsigned ASC_CLK_NS     = 20;
    localparam int unsigned ASC_BT_BASE_CYC = ASC_BT_BASE_NS / ASC_CLK_NS;
    // intervals 0.064/0.128/0.256/1.024 ms as multiples of base
    localparam logic [4:0] ASC_MUL_0 = 5'd1;
    localparam logic [4:0] ASC_MUL_1 = 5'd2;
    localparam logic [4:0] ASC_MUL_2 = 5'd4;
    localparam logic [4:0] ASC_MUL_3 = 5'd16;
    localparam int unsigned ASC_BT_BIT3 = 3;

    typedef enum logic [1:0] {
        ASC_OUT_PP  = 2'b00,
        ASC_OUT_DAC = 2'b01,
        ASC_OUT_PWM = 2'b11
    } asc_out_t;

    typedef enum logic [1:0] {
        ASC_OP_NONE  = 2'b00,
        ASC_OP_START = 2'b01,
        ASC_OP_STOP  = 2'b11,
        ASC_OP_SECT  = 2'b10
    } asc_op_t;

    typedef struct packed {
        logic                irq_en;
        logic                audio_en;
        logic                nfilt_en;
        logic                mixer_en;
        asc_out_t            out_sel;
        logic [3:0]          volume;
        logic [ASC_NUM_CH-1:0] ch_active;
    } asc_cfg_t;

    typedef struct packed {
        logic [ASC_CH_W-1:0] ch;
        logic [7:0]          env;
        logic                tail_en;
        logic                head_adpcm;
        logic                tail_adpcm;
    } asc_chan_t;
endpackage : asc_pkg

// *** logic/asc_regs.sv ***
// asc_regs: control/status register bank of the 8-channel synthesizer.
// assumes one Avalon-MM master (the core) on clk, word addressed by 4x index.
// Functional notes
// [RULE1] channel-count field selects 8, 6, 4 or 2 active channels
// [RULE2] six-channel setting runs slots 0,1,2,3,4,5,2,3
// [RULE3] bits 3:2 pick push-pull (0x), DAC (10) or PWM (11)
// [RULE4] push-pull mode mixes every active channel onto one output
// [RULE5] software avoids changing output stage while playing
// [RULE6] mixer volume has sixteen steps, 0x0 quietest, 0xF loudest
// [RULE7] software picks volume per channel count: 2,3,4,8,F
// [RULE8] enable bit 0 gates the timer interrupt; interval set first
// [RULE9] enable bit 1 turns audio output on; configure first
// [RULE10] enable bit 2 turns noise filter on; not cleared in playback
// [RULE11] enable bit 3 turns the channel mixer on
// [RULE12] audio level reads top four sample bits, two's complement
// [RULE13] channel selector steers envelope and decoder-mode copies
// [RULE14] channel operations act only on the selected channel
// [RULE15] selector also names one of 15 pointer/stack locations
// [RULE16] envelope updates only when the high nibble is written
// [RULE17] decoder-mode bit 1 includes the tail waveform
// [RULE18] tail-only melody uses head plus tail with equal waves
// [RULE19] decoder-mode bits 3:2 switch the adaptive decoder per wave
// [RULE20] timer register read returns the base timer counter
// [RULE21] timer register low bits select the interrupt period
//
// Added by the designer: the Avalon-MM slave port.
`default_nettype none
module asc_regs
    import asc_pkg::*;
#(
    parameter int unsigned BT_BASE_CYC = asc_pkg::ASC_BT_BASE_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              clk_en,
    input  wire logic [asc_pkg::ASC_ADDR_W+1:0]    avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output logic      [31:0]                       avs_readdata,
    output logic                                   avs_waitrequest,
    input  wire logic [asc_pkg::ASC_SAMPLE_W-1:0]  mixer_sample,
    input  wire logic                              chan_op_valid,
    input  wire asc_pkg::asc_op_t                  chan_op,
    output asc_pkg::asc_cfg_t                      cfg,
    output asc_pkg::asc_chan_t                     sel_chan,
    output asc_pkg::asc_op_t                       op_out,
    output logic      [asc_pkg::ASC_NUM_CH-1:0]    op_target,
    output logic      [asc_pkg::ASC_PTR_W-1:0]     ptr_loc,
    output logic      [asc_pkg::ASC_CH_W-1:0]      slot_ch,
    output logic                                   timer_irq
);
    import asc_pkg::*;

    logic [3:0]            charc;
    logic [3:0]            volume;
    logic [3:0]            enables;
    logic [3:0]            chsel;
    logic [1:0]            int_sel;
    logic [3:0]            env_lo_stage [ASC_NUM_CH];
    logic [7:0]            env          [ASC_NUM_CH];
    logic [3:0]            decmd        [ASC_NUM_CH];
    // one extra bit: the top readable bit must follow 1.024 ms, not 0.512
    logic [ASC_BT_W:0]     bt_count;
    logic                  bt_tick;
    logic [5:0]            irq_span;
    logic                  irq_wrap;
    logic [31:0]           bt_div;
    logic [4:0]            irq_div;
    logic [2:0]            slot;
    logic                  ack;
    logic [3:0]            aud_level;
    logic                  acc;
    logic                  wr_hit;
    logic [ASC_ADDR_W-1:0] idx;
    logic [ASC_CH_W-1:0]   ch;
    logic [3:0]            wnib;

    assign acc    = (avs_read || avs_write) && !ack;
    assign wr_hit = clk_en && avs_write && !ack && avs_byteenable[0];
    assign idx    = avs_address[ASC_ADDR_W+1:2];
    assign ch     = chsel[ASC_CH_W-1:0]; // RULE13
    assign wnib   = avs_writedata[3:0];
    assign ack    = !avs_waitrequest;

    function automatic logic [ASC_NUM_CH-1:0] active_mask(input logic [1:0] cnt);
        unique case (cnt)
            ASC_CNT_8: active_mask = 8'hFF;
            ASC_CNT_6: active_mask = 8'h3F;
            ASC_CNT_4: active_mask = 8'h0F;
            ASC_CNT_2: active_mask = 8'h03;
        endcase
    endfunction : active_mask

    function automatic asc_out_t out_stage(input logic [1:0] sel);
        if (!sel[1]) begin
            out_stage = ASC_OUT_PP;
        end else if (!sel[0]) begin
            out_stage = ASC_OUT_DAC;
        end else begin
            out_stage = ASC_OUT_PWM;
        end
    endfunction : out_stage

    function automatic logic [4:0] int_mult(input logic [1:0] sel);
        unique case (sel)
            2'b00: int_mult = ASC_MUL_0;
            2'b01: int_mult = ASC_MUL_1;
            2'b10: int_mult = ASC_MUL_2;
            2'b11: int_mult = ASC_MUL_3;
        endcase
    endfunction : int_mult

    // one wait cycle per access; the answer lasts one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= !acc;
        end
    end

    // global control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charc   <= ASC_RST_CHARC;
            volume  <= ASC_RST_VOL;
            enables <= ASC_RST_ENABLES;
            chsel   <= ASC_RST_CHSEL;
            int_sel <= ASC_RST_TIMER[1:0];
        end else if (wr_hit) begin
            unique case (idx)
                ASC_IDX_CHARC:   charc   <= wnib; // RULE1 RULE3
                ASC_IDX_VOL:     volume  <= wnib; // RULE6
                ASC_IDX_ENABLES: enables <= wnib; // RULE8 RULE9 RULE10 RULE11
                ASC_IDX_CHSEL:   chsel   <= wnib; // RULE13 RULE15
                ASC_IDX_TIMER:   int_sel <= wnib[1:0]; // RULE21
                default: ;
            endcase
        end
    end

    // per-channel copies, steered by the selector
    generate
        for (genvar i = 0; i < ASC_NUM_CH; i++) begin : g_ch
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    env_lo_stage[i] <= ASC_RST_ENV[3:0];
                    env[i]          <= ASC_RST_ENV;
                    decmd[i]        <= ASC_RST_DECMD;
                end else if (wr_hit && ch == ASC_CH_W'(i)) begin // RULE13
                    if (idx == ASC_IDX_ENV_LO) begin
                        env_lo_stage[i] <= wnib;
                    end
                    // low nibble is staged; envelope moves as a byte
                    if (idx == ASC_IDX_ENV_HI) begin
                        env[i] <= {wnib, env_lo_stage[i]}; // RULE16
                    end
                    if (idx == ASC_IDX_DECMD) begin
                        decmd[i] <= wnib; // RULE17 RULE19
                    end
                end
            end
        end
    endgenerate

    // RULE12: top four bits of the 13-bit sample, sign first
    assign aud_level = mixer_sample[ASC_SAMPLE_W-1 -: 4];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            avs_readdata <= 32'h0000_0000;
            if (avs_read && !ack) begin
                unique case (idx)
                    ASC_IDX_ENV_LO:  avs_readdata[3:0] <= env_lo_stage[ch];
                    ASC_IDX_ENV_HI:  avs_readdata[3:0] <= env[ch][7:4];
                    ASC_IDX_CHARC:   avs_readdata[3:0] <= charc;
                    ASC_IDX_AUD:     avs_readdata[3:0] <= aud_level; // RULE12
                    ASC_IDX_TIMER:   avs_readdata[3:0] <= {bt_count[ASC_BT_W],
                                                           bt_count[ASC_BT_W-2:0]}; // RULE20
                    ASC_IDX_DECMD:   avs_readdata[3:0] <= decmd[ch];
                    ASC_IDX_ENABLES: avs_readdata[3:0] <= enables;
                    ASC_IDX_VOL:     avs_readdata[3:0] <= volume;
                    ASC_IDX_CHSEL:   avs_readdata[3:0] <= chsel;
                    default: ;
                endcase
            end
        end
    end

    // base timer: ticks every half base interval
    assign bt_tick  = bt_div == BT_BASE_CYC / 2 - 1;
    // period in half-interval ticks; >= keeps a shortened period safe
    assign irq_span = {int_mult(int_sel), 1'b0}; // RULE21
    assign irq_wrap = {1'b0, irq_div} + 6'h01 >= irq_span;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bt_div   <= 32'h0000_0000;
            bt_count <= '0;
            irq_div  <= 5'h00;
        end else if (clk_en) begin
            if (bt_tick) begin
                bt_div   <= 32'h0000_0000;
                bt_count <= bt_count + 1'b1; // RULE20
                irq_div  <= irq_wrap ? 5'h00 : irq_div + 5'h01;
            end else begin
                bt_div <= bt_div + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq <= 1'b0;
        end else if (clk_en) begin
            timer_irq <= enables[ASC_EN_IRQ] && bt_tick && irq_wrap; // RULE8 RULE21
        end
    end

    // synthesis slot sequencer: eight slots per sample cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot    <= 3'h0;
            slot_ch <= '0;
        end else if (clk_en) begin
            slot <= slot + 1'b1;
            unique case (charc[1:0]) // RULE1
                ASC_CNT_8: slot_ch <= slot;
                ASC_CNT_6: slot_ch <= slot[2:1] == 2'b11 ? {1'b0, slot[1:0]} : slot; // RULE2
                ASC_CNT_4: slot_ch <= {1'b0, slot[1:0]};
                ASC_CNT_2: slot_ch <= {2'b00, slot[0]};
            endcase
        end
    end

    // configuration and selected-channel view
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg       <= '0;
            sel_chan  <= '0;
            op_out    <= ASC_OP_NONE;
            op_target <= '0;
            ptr_loc   <= '0;
        end else if (clk_en) begin
            cfg.irq_en    <= enables[ASC_EN_IRQ]; // RULE8
            cfg.audio_en  <= enables[ASC_EN_AUDIO]; // RULE9
            cfg.nfilt_en  <= enables[ASC_EN_NFILT]; // RULE10
            cfg.mixer_en  <= enables[ASC_EN_MIXER]; // RULE11
            cfg.out_sel   <= out_stage(charc[3:2]); // RULE3 RULE4
            cfg.volume    <= volume; // RULE6
            cfg.ch_active <= active_mask(charc[1:0]); // RULE1 RULE2
            sel_chan.ch         <= ch;
            sel_chan.env        <= env[ch];
            sel_chan.tail_en    <= decmd[ch][ASC_DM_TAIL]; // RULE17
            sel_chan.head_adpcm <= decmd[ch][ASC_DM_HDEC]; // RULE19
            sel_chan.tail_adpcm <= decmd[ch][ASC_DM_TDEC]; // RULE19
            ptr_loc <= chsel == 4'hF ? 4'hE : chsel; // RULE15
            op_out  <= chan_op_valid ? chan_op : ASC_OP_NONE;
            op_target <= chan_op_valid ? (8'h01 << ch) : 8'h00; // RULE14
        end
    end
endmodule : asc_regs
`default_nettype wire

// *** bench/asc_regs_monitor.sv ***
// asc_regs_monitor: bus timing and output relations of the register bank.
// assumes clk_en held high; attached to asc_regs by the bind at the foot.
`default_nettype none
module asc_regs_monitor
    import asc_pkg::*;
#(
    parameter int unsigned BT_BASE_CYC = asc_pkg::ASC_BT_BASE_CYC
) (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic               avs_waitrequest,
    input wire logic [31:0]        avs_readdata,
    input wire logic               chan_op_valid,
    input wire asc_pkg::asc_op_t   chan_op,
    input wire asc_pkg::asc_cfg_t  cfg,
    input wire asc_pkg::asc_chan_t sel_chan,
    input wire asc_pkg::asc_op_t   op_out,
    input wire logic [7:0]         op_target,
    input wire logic [3:0]         ptr_loc,
    input wire logic               timer_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack_once;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property (s_take |=> s_ack_once)
        else $error("access not answered in one cycle");
    rd_upper_a: assert property (avs_readdata[31:4] == 28'h0)
        else $error("read data upper bits not zero");
    cnt_active_a: assert property ($past(rst_n) |-> cfg.ch_active inside {8'hFF, 8'h3F, 8'h0F, 8'h03})
        else $error("illegal active channel set");
    out_legal_a: assert property (cfg.out_sel != 2'b10)
        else $error("illegal output stage code");
    ptr_map_a: assert property (ptr_loc <= 4'hE && (ptr_loc == 4'hE || ptr_loc[2:0] == sel_chan.ch))
        else $error("pointer location disagrees with selector");
    op_target_a: assert property (op_out != ASC_OP_NONE |-> op_target == (8'h01 << sel_chan.ch))
        else $error("operation not aimed at selected channel");
    op_echo_a: assert property (chan_op_valid |=> op_out == $past(chan_op))
        else $error("operation not passed on");
    op_quiet_a: assert property (!chan_op_valid |=> op_out == ASC_OP_NONE)
        else $error("operation without request");
    irq_gate_a: assert property (timer_irq |-> cfg.irq_en || $past(cfg.irq_en))
        else $error("interrupt while disabled");
    irq_pulse_a: assert property (timer_irq |=> (!timer_irq) [*8])
        else $error("interrupt pulses too close");
endmodule : asc_regs_monitor
bind asc_regs asc_regs_monitor #(.BT_BASE_CYC(BT_BASE_CYC)) u_mon (.clk, .rst_n, .avs_read,
    .avs_write, .avs_waitrequest, .avs_readdata, .chan_op_valid, .chan_op, .cfg, .sel_chan,
    .op_out, .op_target, .ptr_loc, .timer_irq);
`default_nettype wire

// *** bench/test_asc_regs.sv ***
// test_asc_regs: self-checking bench for the synthesizer register bank.
// assumes the bench is the only bus master; base timer shortened to 16 cycles.
`default_nettype none
module test_asc_regs
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BT = 16;
    logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'hF412, q;
    logic [3:0]  avs_byteenable = 4'hF, ptr_loc, d, a;
    logic        avs_waitrequest, chan_op_valid = 1'b0, timer_irq;
    logic [12:0] mixer_sample = 13'h0000;
    logic [7:0]  op_target, env_m [8];
    logic [3:0]  dm_m [8];
    logic [2:0]  slot_ch;
    asc_op_t     chan_op = ASC_OP_NONE, op_out;
    asc_cfg_t    cfg;
    asc_chan_t   sel_chan;
    int          failures = 0, total_checks = 0, cyc = 0, k, sc [8];
    int          mul [4] = '{1, 2, 4, 16};

    asc_regs #(.BT_BASE_CYC(BT)) dut (.clk, .rst_n, .clk_en(1'b1), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .mixer_sample, .chan_op_valid, .chan_op, .cfg, .sel_chan, .op_out, .op_target,
        .ptr_loc, .slot_ch, .timer_irq);

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    function automatic void step();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction : step

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // request held until waitrequest is sampled low; no latency assumed
    task automatic acc(input logic w, input logic [7:0] i, input logic [3:0] v);
        @(posedge clk);
        avs_address   <= {i, 2'b00};
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= {28'h0, v};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : acc

    task automatic rdc(input logic [7:0] i, input logic [3:0] v);
        acc(1'b0, i, 4'h0);
        chk(q, {28'h0, v});
    endtask : rdc

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdc(ASC_IDX_CHARC, ASC_RST_CHARC);
        rdc(ASC_IDX_VOL, ASC_RST_VOL);
        rdc(ASC_IDX_ENABLES, ASC_RST_ENABLES);
        rdc(ASC_IDX_CHSEL, ASC_RST_CHSEL);
        rdc(ASC_IDX_DECMD, ASC_RST_DECMD);
        acc(1'b1, 8'h10, 4'hA);
        rdc(8'h10, 4'h0);
        avs_byteenable <= 4'h0;
        acc(1'b1, ASC_IDX_VOL, 4'h5);
        avs_byteenable <= 4'hF;
        rdc(ASC_IDX_VOL, ASC_RST_VOL);
        $display("test reset finished");
        for (int v = 0; v < 16; v++) begin // the stage changes while the previous random enables may have audio on
            acc(1'b1, ASC_IDX_CHARC, v[3:0]);
            rdc(ASC_IDX_CHARC, v[3:0]);
            chk(cfg.ch_active, 8'hFF >> (2 * v[1:0]));
            chk(cfg.out_sel, v[3] ? {v[2], 1'b1} : 2'b00);
            acc(1'b1, ASC_IDX_VOL, v[3:0]);
            rdc(ASC_IDX_VOL, v[3:0]);
            chk(cfg.volume, v[3:0]);
            step();
            d = seed[3:0];
            acc(1'b1, ASC_IDX_ENABLES, d);
            rdc(ASC_IDX_ENABLES, d);
            chk({cfg.irq_en, cfg.audio_en, cfg.nfilt_en, cfg.mixer_en}, {d[0], d[1], d[2], d[3]});
        end
        // six channels: slots 2 and 3 come twice per round
        acc(1'b1, ASC_IDX_CHARC, 4'h1);
        acc(1'b1, ASC_IDX_VOL, 4'h3);
        rdc(ASC_IDX_VOL, 4'h3);
        sc = '{default: 0};
        repeat (64) begin
            @(posedge clk);
            sc[slot_ch]++;
        end
        chk(sc[6] + sc[7], 0);
        chk(sc[2], 2 * sc[0]);
        for (int j = 0; j < 9; j++) begin
            step();
            mixer_sample <= (j == 0) ? 13'h1000 : seed[12:0];
            acc(1'b0, ASC_IDX_AUD, 4'h0);
            chk(q, {28'h0, mixer_sample[12:9]});
        end
        $display("test config finished");
        for (int c = 0; c < 8; c++) begin
            step();
            env_m[c] = seed[7:0];
            dm_m[c] = seed[11:8];
            acc(1'b1, ASC_IDX_CHSEL, c[3:0]);
            acc(1'b1, ASC_IDX_ENV_LO, env_m[c][3:0]);
            acc(1'b1, ASC_IDX_ENV_HI, env_m[c][7:4]);
            acc(1'b1, ASC_IDX_DECMD, dm_m[c]);
        end
        for (int s = 0; s < 16; s++) begin
            acc(1'b1, ASC_IDX_CHSEL, s[3:0]);
            rdc(ASC_IDX_CHSEL, s[3:0]);
            chk(sel_chan.env, env_m[s[2:0]]);
            chk({sel_chan.tail_adpcm, sel_chan.head_adpcm, sel_chan.tail_en}, dm_m[s[2:0]][3:1]);
            chk(ptr_loc, (s == 15) ? 4'hE : s[3:0]);
            acc(1'b0, ASC_IDX_DECMD, 4'h0);
            chk(q[3:1], dm_m[s[2:0]][3:1]);
            @(posedge clk) begin
                chan_op_valid <= 1'b1;
                chan_op <= asc_op_t'(s[1:0]);
            end
            @(posedge clk) chan_op_valid <= 1'b0;
            @(posedge clk) chk(op_out, s[1:0]);
            chk(op_target, 8'h01 << s[2:0]);
        end
        acc(1'b1, ASC_IDX_CHSEL, 4'h0);
        acc(1'b1, ASC_IDX_ENV_LO, ~env_m[0][3:0]);
        acc(1'b0, ASC_IDX_CHSEL, 4'h0);
        chk(sel_chan.env, env_m[0]);
        acc(1'b1, ASC_IDX_ENV_HI, 4'h5);
        acc(1'b0, ASC_IDX_CHSEL, 4'h0);
        chk(sel_chan.env, {4'h5, ~env_m[0][3:0]});
        $display("test channels finished");
        // counter steps every half base interval: 16 cycles give two steps
        acc(1'b0, ASC_IDX_TIMER, 4'h0);
        a = q[3:0];
        repeat (13) @(posedge clk);
        acc(1'b0, ASC_IDX_TIMER, 4'h0);
        chk(q[2:0], a[2:0] + 3'h2);
        // top bit toggles every 16 ticks: 128 cycles flip it, low bits wrap
        acc(1'b0, ASC_IDX_TIMER, 4'h0);
        a = q[3:0];
        repeat (125) @(posedge clk);
        acc(1'b0, ASC_IDX_TIMER, 4'h0);
        chk(q[3:0], {~a[3], a[2:0]});
        acc(1'b1, ASC_IDX_ENABLES, 4'h1);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) acc(1'b1, ASC_IDX_ENABLES, 4'h0);
            else acc(1'b1, ASC_IDX_TIMER, i[3:0]);
            repeat (BT * mul[i % 4]) @(posedge clk);
            k = 0;
            repeat (2 * BT * mul[i % 4]) begin
                @(posedge clk);
                if (timer_irq === 1'b1) k++;
            end
            chk(k, (i == 4) ? 0 : 2);
        end
        $display("test timer finished");
        tally_and_finish();
    end
endmodule : test_asc_regs
`default_nettype wire
